// File: core/nas_pkg.sv
// Constants, register map and state type for the service-port address selector.
// Assumes a 10 MHz clock and a 32-bit AXI4-Lite register bus.
package nas_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SOFT_ADDR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_ACTIVE_ADDR = 8'h0C;
  localparam logic [7:0] OFF_NET_MASK = 8'h10;
  localparam logic [7:0] OFF_DISPLAY = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_SRC_BIT = 0;
  localparam int ST_DYN_BIT = 0;
  localparam int ST_LL_BIT = 1;
  localparam int ST_BOUND_BIT = 2;
  localparam int ST_FLASH_BIT = 3;
  localparam int ST_LINK_BIT = 4;
  localparam int ST_RUN_BIT = 5;
  localparam int ST_VAR_BIT = 6;
  localparam int ST_SW_LSB = 8;

  // ----------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------
  localparam logic CTRL_SRC_RST = 1'b0;
  localparam logic SRC_SOFT = 1'b1;
  localparam logic [31:0] SOFT_ADDR_RST = 32'hC0A8_0165;
  localparam logic [31:0] NET_MASK = 32'hFFFF_FF00;
  localparam logic [23:0] STATIC_NET = 24'hC0_A800;
  localparam logic [15:0] LINKLOCAL_NET = 16'hA9FE;
  localparam logic [31:0] ZERO_ADDR = 32'h0000_0000;
  localparam logic [7:0] SINGLE_BASE = 8'h64;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int HOLD_TIME_MS = 5000;
  localparam int DEBOUNCE_MS = 20;
  localparam int FLASH_MS = 3000;
  localparam int SHOW_MS = 10000;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);
  localparam int SHOW_CYCLES = SHOW_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    NAS_BOOT, NAS_DHCP, NAS_BOUND, NAS_LINKLOCAL, NAS_STATIC, NAS_FLASH
  } nas_state_t;

endpackage

// File: core/nas_hold_timer.sv
// Debounce and hold-time measurement for the top push button.
// Assumes the button input is already synchronous to clk.
module nas_hold_timer
  import nas_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int HLD_CYCLES = HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Button
  input wire logic button_in,
  // Results
  output logic pressed,
  output logic press_start,
  output logic hold_hit
);

  logic [31:0] deb_cnt_r, deb_cnt_nxt;
  logic [31:0] hold_cnt_r, hold_cnt_nxt;
  logic stable_r, stable_nxt;
  logic done_r, done_nxt;
  logic start_r, start_nxt;
  logic hit_r, hit_nxt;

  always_comb begin
    deb_cnt_nxt = 32'h0000_0000;
    stable_nxt = stable_r;
    start_nxt = 1'b0;
    hit_nxt = 1'b0;
    hold_cnt_nxt = 32'h0000_0000;
    done_nxt = 1'b0;
    // Input must disagree for a full window before the level flips
    if (button_in != stable_r) begin
      if (deb_cnt_r >= 32'(DEB_CYCLES - 1)) begin
        stable_nxt = button_in;
        start_nxt = button_in;
      end else begin
        deb_cnt_nxt = deb_cnt_r + 32'h0000_0001;
      end
    end
    // One hit per continuous press; released level re-arms it
    if (stable_r) begin
      done_nxt = done_r;
      hold_cnt_nxt = hold_cnt_r;
      if (!done_r) begin
        hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
        if (hold_cnt_r == 32'(HLD_CYCLES - 1)) begin
          hit_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_cnt_r <= 32'h0000_0000;
      hold_cnt_r <= 32'h0000_0000;
      stable_r <= 1'b0;
      done_r <= 1'b0;
      start_r <= 1'b0;
      hit_r <= 1'b0;
    end else begin
      deb_cnt_r <= deb_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      stable_r <= stable_nxt;
      done_r <= done_nxt;
      start_r <= start_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign pressed = stable_r;
  assign press_start = start_r;
  assign hold_hit = hit_r;

endmodule // nas_hold_timer

// File: core/nas_addr_select.sv
// Service-port network address selector with AXI4-Lite registers.
// Assumes a MAC/IP stack outside reports DHCP results, link and session state.
//
// Operation
// - Two switches both zero request DHCP
// - Two-switch value 1-99 gives 192.168.0.nn
// - No DHCP answer falls back to link-local
// - Switches sampled only at power-up
// - Stored source one boots software static address (single variant: position one only; other positions give 192.168.0.100+n);
//   here reset clears ctrl_src_r to 0 as it enters NAS_BOOT, so the boot always follows the switches
// - Zero switches plus 5 s hold restores defaults
// - Single variant shows address only with cable
// - Single switch zero requests DHCP with fallback
// - Single position one uses software address
// - Single positions 2-9 give 192.168.0.10n
// - Single switch also read only at power-up
// - Fixed 255.255.255.0 mask, peer shares prefix
// - Link lamp follows port link
// - Run lamp follows Modbus communication
// - HMI reads and writes parameters over Modbus
// - Modbus and setup sessions run together
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module nas_addr_select
  import nas_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int HLD_CYCLES = HOLD_CYCLES,
  parameter int FLS_CYCLES = FLASH_CYCLES,
  parameter int SHW_CYCLES = SHOW_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Front panel
  input wire logic [3:0] upper_address_digit_switch,
  input wire logic [3:0] lower_address_digit_switch,
  input wire logic [3:0] single_address_switch,
  input wire logic single_switch_variant,
  input wire logic top_push_button,
  // Network stack
  input wire logic link_up,
  input wire logic dhcp_lease_valid,
  input wire logic [31:0] dhcp_lease_addr,
  input wire logic dhcp_no_server,
  input wire logic modbus_session,
  input wire logic setup_session,
  input wire logic [31:0] peer_addr,
  // Address result
  output logic [31:0] net_addr,
  output logic [31:0] net_mask,
  output logic addr_valid,
  output logic dhcp_request,
  output logic peer_reachable,
  output logic service_enable,
  // Display and lamps
  output logic [31:0] display_addr,
  output logic display_on,
  output logic display_flash,
  output logic link_indicator_lamp,
  output logic run_indicator_lamp
);

  // ----------------------------------------
  // Button
  // ----------------------------------------
  logic btn_start, btn_hit;

  nas_hold_timer #(
    .DEB_CYCLES(DEB_CYCLES),
    .HLD_CYCLES(HLD_CYCLES)
  ) u_hold (
    .clk(clk),
    .reset_n(reset_n),
    .button_in(top_push_button),
    .pressed(),
    .press_start(btn_start),
    .hold_hit(btn_hit)
  );

  // ----------------------------------------
  // Address state machine
  // ----------------------------------------
  nas_state_t state_r, state_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [3:0] sw_up_r, sw_up_nxt, sw_lo_r, sw_lo_nxt, sw_one_r, sw_one_nxt;
  logic variant_r, variant_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [31:0] show_r, show_nxt;
  logic link_r, run_r, disp_on_r, disp_on_nxt;
  logic [31:0] disp_r, disp_nxt;
  logic recover;
  logic ctrl_src_r;
  logic [31:0] soft_addr_r;
  logic [7:0] two_val, ll_hi;

  // Digits above nine are read as nine
  function automatic logic [3:0] clip(input logic [3:0] d);
    return (d > DIGIT_MAX) ? DIGIT_MAX : d;
  endfunction

  always_comb begin
    two_val = 8'({4'h0, clip(sw_up_r)} * 8'h0A) + 8'({4'h0, clip(sw_lo_r)});
    ll_hi = lfsr_r[15:8];
    if (ll_hi == 8'h00) begin
      ll_hi = 8'h01;
    end else if (ll_hi == 8'hFF) begin
      ll_hi = 8'hFE;
    end
  end

  // Recovery only counts zero switches as they stand during the press
  assign recover = btn_hit && !variant_r && (state_r != NAS_BOOT) &&
                   (upper_address_digit_switch == 4'h0) &&
                   (lower_address_digit_switch == 4'h0);

  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    sw_up_nxt = sw_up_r;
    sw_lo_nxt = sw_lo_r;
    sw_one_nxt = sw_one_r;
    variant_nxt = variant_r;
    tmr_nxt = (tmr_r != 32'h0000_0000) ? tmr_r - 32'h0000_0001 : tmr_r;
    lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    case (state_r)
      NAS_BOOT: begin
        // Switches are latched once; later changes wait for a power cycle
        sw_up_nxt = upper_address_digit_switch;
        sw_lo_nxt = lower_address_digit_switch;
        sw_one_nxt = single_address_switch;
        variant_nxt = single_switch_variant;
        if (ctrl_src_r == SRC_SOFT) begin
          addr_nxt = soft_addr_r;
          state_nxt = NAS_STATIC;
        end else if (!single_switch_variant) begin
          if ((upper_address_digit_switch == 4'h0) &&
              (lower_address_digit_switch == 4'h0)) begin
            state_nxt = NAS_DHCP;
          end else begin
            state_nxt = NAS_STATIC;
          end
        end else if ((single_address_switch == 4'h0) ||
                     (single_address_switch > DIGIT_MAX)) begin
          state_nxt = NAS_DHCP;
        end else if (single_address_switch == 4'h1) begin
          addr_nxt = soft_addr_r;
          state_nxt = NAS_STATIC;
        end else begin
          state_nxt = NAS_STATIC;
        end
      end
      NAS_STATIC: begin
        // Numeric forms are resolved one cycle after the latch
        if (ctrl_src_r != SRC_SOFT || variant_r && sw_one_r != 4'h1) begin
          if (!variant_r) begin
            addr_nxt = {STATIC_NET, two_val};
          end else if (sw_one_r != 4'h1) begin
            addr_nxt = {STATIC_NET, SINGLE_BASE + {4'h0, sw_one_r}};
          end
        end
      end
      NAS_DHCP: begin
        addr_nxt = ZERO_ADDR;
        if (dhcp_lease_valid) begin
          addr_nxt = dhcp_lease_addr;
          state_nxt = NAS_BOUND;
        end else if (dhcp_no_server) begin
          addr_nxt = {LINKLOCAL_NET, ll_hi, lfsr_r[7:0]};
          state_nxt = NAS_LINKLOCAL;
        end
      end
      NAS_LINKLOCAL: begin
        // A late server still wins over the self-made address
        if (dhcp_lease_valid) begin
          addr_nxt = dhcp_lease_addr;
          state_nxt = NAS_BOUND;
        end
      end
      NAS_BOUND: begin
        if (!dhcp_lease_valid) begin
          state_nxt = NAS_DHCP;
        end
      end
      NAS_FLASH: begin
        addr_nxt = ZERO_ADDR;
        if (tmr_r == 32'h0000_0000) begin
          state_nxt = NAS_DHCP;
        end
      end
      default: begin
        state_nxt = NAS_BOOT;
      end
    endcase
    if (recover) begin
      state_nxt = NAS_FLASH;
      addr_nxt = ZERO_ADDR;
      tmr_nxt = 32'(FLS_CYCLES - 1);
    end
  end

  // ----------------------------------------
  // Display and lamps
  // ----------------------------------------
  always_comb begin
    show_nxt = (show_r != 32'h0000_0000) ? show_r - 32'h0000_0001 : show_r;
    if ((state_r == NAS_BOOT) || (variant_r && link_up && !link_r)) begin
      show_nxt = 32'(SHW_CYCLES);
    end else if (!variant_r && btn_start) begin
      show_nxt = 32'(SHW_CYCLES);
    end
    disp_nxt = (state_r == NAS_FLASH) ? ZERO_ADDR : addr_r;
    // Single variant keeps the display dark without a cable
    disp_on_nxt = (state_r == NAS_FLASH) ||
                  ((show_r != 32'h0000_0000) && (!variant_r || link_up));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= NAS_BOOT;
      addr_r <= ZERO_ADDR;
      sw_up_r <= 4'h0;
      sw_lo_r <= 4'h0;
      sw_one_r <= 4'h0;
      variant_r <= 1'b0;
      lfsr_r <= LFSR_SEED;
      tmr_r <= 32'h0000_0000;
      show_r <= 32'h0000_0000;
      disp_r <= ZERO_ADDR;
      disp_on_r <= 1'b0;
      link_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      sw_up_r <= sw_up_nxt;
      sw_lo_r <= sw_lo_nxt;
      sw_one_r <= sw_one_nxt;
      variant_r <= variant_nxt;
      lfsr_r <= lfsr_nxt;
      tmr_r <= tmr_nxt;
      show_r <= show_nxt;
      disp_r <= disp_nxt;
      disp_on_r <= disp_on_nxt;
      link_r <= link_up;
      run_r <= modbus_session;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic ctrl_src_nxt;
  logic [31:0] soft_addr_nxt, rdata_r, rdata_nxt, status;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_go, rd_go;

  // Address and data are taken in the same cycle
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;

  always_comb begin
    status = 32'h0000_0000;
    status[ST_DYN_BIT] = (state_r == NAS_DHCP);
    status[ST_LL_BIT] = (state_r == NAS_LINKLOCAL);
    status[ST_BOUND_BIT] = (state_r == NAS_BOUND);
    status[ST_FLASH_BIT] = (state_r == NAS_FLASH);
    status[ST_LINK_BIT] = link_r;
    status[ST_RUN_BIT] = run_r;
    status[ST_VAR_BIT] = variant_r;
    status[ST_SW_LSB +: 8] = variant_r ? {4'h0, sw_one_r} : {sw_up_r, sw_lo_r};
  end

  always_comb begin
    ctrl_src_nxt = ctrl_src_r;
    soft_addr_nxt = soft_addr_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (s_axi_awaddr == OFF_CTRL) begin
        if (s_axi_wstrb[0]) begin
          ctrl_src_nxt = s_axi_wdata[CTRL_SRC_BIT];
        end
      end else if (s_axi_awaddr == OFF_SOFT_ADDR) begin
        for (int b = 0; b < 4; b++) begin
          if (s_axi_wstrb[b]) begin
            soft_addr_nxt[8*b +: 8] = s_axi_wdata[8*b +: 8];
          end
        end
      end else if (!((s_axi_awaddr == OFF_STATUS) || (s_axi_awaddr == OFF_ACTIVE_ADDR) ||
                     (s_axi_awaddr == OFF_NET_MASK) || (s_axi_awaddr == OFF_DISPLAY))) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    // Hardware recovery overrides a software write in the same cycle
    if (recover) begin
      ctrl_src_nxt = CTRL_SRC_RST;
      soft_addr_nxt = SOFT_ADDR_RST;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL: rdata_nxt = {31'h0000_0000, ctrl_src_r};
        OFF_SOFT_ADDR: rdata_nxt = soft_addr_r;
        OFF_STATUS: rdata_nxt = status;
        OFF_ACTIVE_ADDR: rdata_nxt = addr_r;
        OFF_NET_MASK: rdata_nxt = NET_MASK;
        OFF_DISPLAY: rdata_nxt = disp_r;
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_src_r <= CTRL_SRC_RST;
      soft_addr_r <= SOFT_ADDR_RST;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_src_r <= ctrl_src_nxt;
      soft_addr_r <= soft_addr_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign net_addr = addr_r;
  assign net_mask = NET_MASK;
  assign addr_valid = (state_r == NAS_STATIC) || (state_r == NAS_BOUND) ||
                      (state_r == NAS_LINKLOCAL);
  assign dhcp_request = (state_r == NAS_DHCP);
  assign peer_reachable = (peer_addr[31:8] == addr_r[31:8]) &&
                          (peer_addr[7:0] != addr_r[7:0]);
  // Sessions are not arbitrated; the session term is tied true so both share the port
  assign service_enable = addr_valid && link_r &&
                          (modbus_session || setup_session || 1'b1);
  assign display_addr = disp_r;
  assign display_on = disp_on_r;
  assign display_flash = (state_r == NAS_FLASH);
  assign link_indicator_lamp = link_r;
  assign run_indicator_lamp = run_r;

endmodule // nas_addr_select

// File: testbench/nas_addr_select_properties.sv
// Port-level checks for the address selector.
// Assumes one clock domain and a bind onto nas_addr_select.
module nas_chk
  import nas_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Inputs
  input wire logic link_up,
  input wire logic modbus_session,
  input wire logic dhcp_lease_valid,
  input wire logic [31:0] dhcp_lease_addr,
  input wire logic dhcp_no_server,
  input wire logic [31:0] peer_addr,
  input wire logic single_switch_variant,
  // Outputs
  input wire logic [31:0] net_addr,
  input wire logic [31:0] net_mask,
  input wire logic addr_valid,
  input wire logic dhcp_request,
  input wire logic peer_reachable,
  input wire logic [31:0] display_addr,
  input wire logic display_on,
  input wire logic display_flash,
  input wire logic link_indicator_lamp,
  input wire logic run_indicator_lamp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_mask; net_mask == NET_MASK; endproperty
  a_mask: assert property (p_mask) else $error("mask changed");
  property p_peer;
    peer_reachable == (peer_addr[31:8] == net_addr[31:8] && peer_addr[7:0] != net_addr[7:0]);
  endproperty
  a_peer: assert property (p_peer) else $error("peer test wrong");
  property p_lease;
    dhcp_request && dhcp_lease_valid |=> addr_valid && net_addr == $past(dhcp_lease_addr);
  endproperty
  a_lease: assert property (p_lease) else $error("lease not taken");
  property p_fall;
    dhcp_request && !dhcp_lease_valid && dhcp_no_server |=>
      addr_valid && net_addr[31:16] == LINKLOCAL_NET;
  endproperty
  a_fall: assert property (p_fall) else $error("no link-local fallback");
  property p_link; (reset_n && link_up)[*2] |-> link_indicator_lamp; endproperty
  a_link: assert property (p_link) else $error("link lamp dark");
  property p_run; !modbus_session[*2] |-> !run_indicator_lamp; endproperty
  a_run: assert property (p_run) else $error("run lamp lit");
  property p_disp; (single_switch_variant && !link_up)[*2] |-> !display_on; endproperty
  a_disp: assert property (p_disp) else $error("display without cable");
  property p_flash;
    $rose(display_flash) |-> ##[0:1] display_addr == ZERO_ADDR && net_addr == ZERO_ADDR;
  endproperty
  a_flash: assert property (p_flash) else $error("flash not zero");
  property p_after; $fell(display_flash) |-> ##[0:2] dhcp_request; endproperty
  a_after: assert property (p_after) else $error("no dhcp after flash");
endmodule // nas_chk

bind nas_addr_select nas_chk u_chk (.clk, .reset_n, .link_up, .modbus_session,
  .dhcp_lease_valid, .dhcp_lease_addr, .dhcp_no_server, .peer_addr, .single_switch_variant,
  .net_addr, .net_mask, .addr_valid, .dhcp_request, .peer_reachable, .display_addr,
  .display_on, .display_flash, .link_indicator_lamp, .run_indicator_lamp);

// File: testbench/nas_net_model.sv
// Network stack stand-in: cable, DHCP server and its delayed answer.
// Assumes dhcp_request is a level held while an answer is wanted.
module nas_net_model #(
  parameter int DLY = 6,
  parameter logic [31:0] LEASE = 32'h0A14_1E28
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Scenario control
  input wire logic cable,
  input wire logic server_on,
  // Selector side
  input wire logic dhcp_request,
  output logic link_up,
  output logic dhcp_lease_valid,
  output logic [31:0] dhcp_lease_addr,
  output logic dhcp_no_server
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  assign link_up = cable;
  // Junk outside a lease, so a stale one never passes as live
  assign dhcp_lease_addr = dhcp_lease_valid ? LEASE : ~LEASE ^ 32'(cnt);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      dhcp_lease_valid <= 1'b0;
      dhcp_no_server <= 1'b0;
    end else begin
      dhcp_no_server <= 1'b0;
      if (!server_on) dhcp_lease_valid <= 1'b0;
      if (dhcp_request && !dhcp_lease_valid) begin
        cnt <= (cnt == DLY) ? 0 : cnt + 1;
        if (cnt == DLY) begin
          dhcp_lease_valid <= server_on;
          dhcp_no_server <= !server_on;
        end
      end
    end
  end
endmodule // nas_net_model

// File: testbench/tb_top.sv
// Self-checking bench for nas_addr_select with a network stack model.
// Assumes the checker is bound from its own file.
module tb_top
  import nas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] LEASE = 32'h0A14_1E28;
  logic clk = 1'b0, reset_n = 1'b0, cable = 1'b0, server_on = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, peer_addr = '0;
  logic [3:0] s_axi_wstrb = '0, upper_address_digit_switch = '0;
  logic [3:0] lower_address_digit_switch = '0, single_address_switch = '0;
  logic single_switch_variant = 1'b0, top_push_button = 1'b0;
  logic modbus_session = 1'b0, setup_session = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic link_up, dhcp_lease_valid, dhcp_no_server, addr_valid, dhcp_request;
  wire logic peer_reachable, service_enable, display_on, display_flash;
  wire logic link_indicator_lamp, run_indicator_lamp;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, dhcp_lease_addr, net_addr, net_mask, display_addr;
  int err_count = 0, checked = 0, cyc = 0;

  // Short counts keep the hold and flash phases to tens of cycles
  nas_addr_select #(.DEB_CYCLES(4), .HLD_CYCLES(20), .FLS_CYCLES(10), .SHW_CYCLES(16)) dut (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .upper_address_digit_switch, .lower_address_digit_switch,
    .single_address_switch, .single_switch_variant, .top_push_button, .link_up,
    .dhcp_lease_valid, .dhcp_lease_addr, .dhcp_no_server, .modbus_session, .setup_session,
    .peer_addr, .net_addr, .net_mask, .addr_valid, .dhcp_request, .peer_reachable,
    .service_enable, .display_addr, .display_on, .display_flash, .link_indicator_lamp,
    .run_indicator_lamp);
  nas_net_model #(.DLY(6), .LEASE(LEASE)) net (.clk, .reset_n, .cable, .server_on,
    .dhcp_request, .link_up, .dhcp_lease_valid, .dhcp_lease_addr, .dhcp_no_server);

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      close_out();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic boot(input bit v, input int up, input int lo, input int s);
    reset_n <= 1'b0;
    single_switch_variant <= v;
    upper_address_digit_switch <= 4'(up);
    lower_address_digit_switch <= 4'(lo);
    single_address_switch <= 4'(s);
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] exp_addr(bit v, int up, int lo, int s);
    if (v) begin
      if (s == 1) return SOFT_ADDR_RST;
      if (s >= 2 && s <= 9) return {STATIC_NET, 8'(100 + s)};
      return ZERO_ADDR;
    end
    if (up == 0 && lo == 0) return ZERO_ADDR;
    return {STATIC_NET, 8'(up * 10 + lo)};
  endfunction

  // ----
  // Scenarios
  // ----
  initial begin
    int up, lo, t;
    logic [31:0] e, d;
    logic [1:0] r;
    void'($urandom(32'h0000_ee6b));
    // Two-digit edges, random digits, then single positions 0 to 11
    for (int i = 0; i < 24; i++) begin
      up = (i == 1) ? 9 : (i < 3) ? 0 : int'($urandom % 10);
      lo = (i == 1) ? 9 : (i < 3) ? i / 2 : int'($urandom % 10);
      boot(i >= 12, up, lo, i - 12);
      e = exp_addr(i >= 12, up, lo, i - 12);
      chk(net_addr, e);
      chk(32'(dhcp_request), 32'(e == 0));
      if (e == 0) begin
        do @(posedge clk); while (addr_valid !== 1'b1);
        chk(32'(net_addr[31:16]), 32'(LINKLOCAL_NET));
      end
      upper_address_digit_switch <= 4'($urandom);
      lower_address_digit_switch <= 4'($urandom);
      single_address_switch <= 4'($urandom);
      repeat (3) @(posedge clk);
      if (e != 0) chk(net_addr, e);
    end
    boot(0, 4, 5, 0);
    rd(OFF_NET_MASK, d, r);
    chk(d, NET_MASK);
    rd(OFF_ACTIVE_ADDR, d, r);
    chk(d, 32'hC0A8_002D);
    rd(8'h18, d, r);
    chk({d[31:2], r}, {30'h0000_0000, RESP_SLVERR});
    wr(OFF_STATUS, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(RESP_OKAY));
    e = $urandom;
    wr(OFF_SOFT_ADDR, e, r);
    rd(OFF_SOFT_ADDR, d, r);
    chk(d, e);
    // Peer on a /24 mask, as a direct PC must be
    for (int i = 0; i < 16; i++) begin
      cable <= 1'($urandom);
      modbus_session <= 1'($urandom);
      setup_session <= 1'($urandom);
      peer_addr <= i[0] ? {24'hC0_A800, 8'($urandom)} : $urandom;
      repeat (2) @(posedge clk);
      chk({30'h0, link_indicator_lamp, service_enable}, {30'h0, cable, cable});
      chk(32'(run_indicator_lamp), 32'(modbus_session));
      chk(32'(peer_reachable), 32'((peer_addr ^ 32'hC0A8_002D) inside {[1:255]}));
    end
    server_on <= 1'b1;
    boot(0, 0, 0, 0);
    do @(posedge clk); while (addr_valid !== 1'b1);
    chk(net_addr, LEASE);
    server_on <= 1'b0;
    cable <= 1'b0;
    boot(1, 0, 0, 5);
    chk(32'(display_on), 32'h0000_0000);
    cable <= 1'b1;
    repeat (3) @(posedge clk);
    chk({display_addr[31:1], display_on}, {STATIC_NET, 7'h34, 1'b1});
    boot(0, 0, 0, 0);
    wr(OFF_SOFT_ADDR, 32'h0A00_0001, r);
    wr(OFF_CTRL, 32'h0000_0001, r);
    top_push_button <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (display_flash !== 1'b1);
    chk(32'(t >= 24 && t <= 32), 32'h0000_0001);
    @(posedge clk);
    chk(display_addr, ZERO_ADDR);
    do @(posedge clk); while (display_flash === 1'b1);
    @(posedge clk);
    chk(32'(dhcp_request), 32'h0000_0001);
    rd(OFF_SOFT_ADDR, d, r);
    chk(d, SOFT_ADDR_RST);
    rd(OFF_CTRL, d, r);
    chk(32'(d[0]), 32'(CTRL_SRC_RST));
    t = 0;
    repeat (40) begin
      @(posedge clk);
      t += int'(display_flash);
    end
    chk(32'(t), 32'h0000_0000);
    close_out();
  end
endmodule // tb_top
